// >>> status_pkg.sv
// Shared constants for the status event reporting block
package status_pkg;
  // Group widths
  localparam int QUES_W = 16;
  localparam int STD_W = 8;
  localparam int STB_W = 8;
  // Questionable-data bit positions
  localparam int QB_OVERLOAD = 0;
  localparam int QB_UNLOCK = 5;
  localparam int QB_CAL = 8;
  localparam int QB_EXTREF = 9;
  // Questionable-data implemented bits, all others read zero
  localparam logic [15:0] QUES_USED = 16'h0321;
  // Standard-event bit positions
  localparam int SB_OPC = 0;
  localparam int SB_QUERY = 2;
  localparam int SB_DEVICE = 3;
  localparam int SB_EXEC = 4;
  localparam int SB_CMD = 5;
  localparam int SB_PWR = 7;
  // Standard-event implemented bits
  localparam logic [7:0] STD_USED = 8'hbd;
  // Status byte bit positions
  localparam int YB_ERRQ = 2;
  localparam int YB_QUES = 3;
  localparam int YB_MAV = 4;
  localparam int YB_STD = 5;
  localparam int YB_RQS = 6;
  // Status byte mask bits that may feed the master summary
  localparam logic [7:0] SRE_USED = 8'h3c;
  // Reset values
  localparam logic [15:0] QUES_MASK_RST = 16'h0000;
  localparam logic [7:0] STD_MASK_RST = 8'h00;
  localparam logic [7:0] SRE_RST = 8'h00;
  localparam logic PSC_RST = 1'b1;
  // Power-up sequencing states
  typedef enum logic [1:0] {
    BOOT_LOAD = 2'b00,
    BOOT_MARK = 2'b01,
    BOOT_RUN = 2'b11
  } boot_t;
endpackage : status_pkg

// >>> evt_if.sv
// Carrier between the top and one latched event group
`timescale 1ns/1ps
interface evt_if #(parameter int W = 8);
  logic [W-1:0] set_ev; // Event strobes, one per bit
  logic clear_ev; // Clear all latched bits
  logic mask_wr; // Mask load strobe
  logic [W-1:0] mask_wdata; // Mask load value
  logic [W-1:0] event_q; // Latched events
  logic [W-1:0] mask_q; // Current mask
  logic summary; // Masked OR of the group
  modport grp (input set_ev, clear_ev, mask_wr, mask_wdata, output event_q, mask_q, summary);
  modport ctl (output set_ev, clear_ev, mask_wr, mask_wdata, input event_q, mask_q, summary);
endinterface : evt_if

// >>> event_group.sv
// One latched event register with its mask and summary bit
`timescale 1ns/1ps
module event_group #(
  parameter int W = 8,
  parameter logic [W-1:0] USED = '1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Group carrier
  evt_if.grp g
);
  // Carrier width must match the group width
  if ($bits(g.event_q) != W) begin : g_bad_width
    $error("event_group width does not match carrier");
  end

  // Masked events, decoded continuously
  wire logic [W-1:0] hit = g.event_q & g.mask_q;

  // Latched events: a set in the clearing cycle survives
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      g.event_q <= '0;
    end else begin
      g.event_q <= (g.clear_ev ? '0 : g.event_q) | (g.set_ev & USED); // [R21] [R11]
    end
  end

  // Mask register; writing zero clears it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      g.mask_q <= '0;
    end else if (g.mask_wr) begin
      g.mask_q <= g.mask_wdata & USED; // [R11]
    end
  end

  // Summary follows either register without delay
  assign g.summary = |hit; // [R23]
endmodule : event_group

// >>> pin_sync.sv
// Three-stage synchroniser with agreement filter per pin
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Raw pins and filtered levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  if (W < 1) begin : g_bad_w
    $error("pin_sync needs at least one bit");
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1; // Metastable stage, read only by s2
    logic s2; // Second stage
    logic s3; // Third stage
    // Shift chain; level moves only when stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        q_o[i] <= 1'b0;
      end else begin
        s1 <= d_i[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          q_o[i] <= s3;
        end
      end
    end
  end
endmodule : pin_sync

// >>> status_event_reporting.sv
// Status byte, questionable-data and standard-event reporting logic
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Message-available bit follows pending output data
// [R2] Host arms service requests in fixed order
// [R3] Host unmasks operation-complete before command string
// [R4] Operation-complete bit set after flagged sequence
// [R5] Standard summary drives status byte bit 5
// [R6] Questionable summary reports only masked bits
// [R7] Overload latches bit 0, disables output
// [R8] Phase-lock loss latches questionable bit 5
// [R9] Calibration fault, loss or unsecure sets bit 8
// [R10] External timebase use sets questionable bit 9
// [R11] Unused status bits always read zero
// [R12] Questionable events cleared by clear-all or read
// [R13] Questionable mask cleared at power, preset, zero
// [R14] Operation complete waits for overlapped work too
// [R15] Query faults set standard bit 2
// [R16] Device-specific errors set standard bit 3
// [R17] Execution error bit 4, syntax error bit 5
// [R18] Power-up sets standard bit 7
// [R19] Standard events cleared by clear-all or read
// [R20] Standard mask: zero write clears, power per setting
// [R21] Event bits latch and hold until cleared
// [R22] Rising master summary raises service request
// [R23] Group summary is masked OR, combinational
module status_event_reporting (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // Asynchronous condition pins
  input wire logic OVLD_PIN_I,
  input wire logic UNLOCK_PIN_I,
  input wire logic EXTREF_PIN_I,
  // Calibration state from the controller
  input wire logic CAL_FAIL_I,
  input wire logic CAL_LOST_I,
  input wire logic CAL_UNSEC_I,
  // Command strobes from the parser
  input wire logic CLS_I,
  input wire logic PRESET_I,
  input wire logic QUES_RD_I,
  input wire logic ESR_RD_I,
  input wire logic QUES_MASK_WR_I,
  input wire logic STD_MASK_WR_I,
  input wire logic SRE_WR_I,
  input wire logic PSC_WR_I,
  input wire logic OPC_I,
  input wire logic [status_pkg::QUES_W-1:0] WDATA_I,
  // Command engine state
  input wire logic CMD_IDLE_I,
  input wire logic OVERLAP_BUSY_I,
  input wire logic OUT_PENDING_I,
  input wire logic ERRQ_NONEMPTY_I,
  // Error reports, one-cycle pulses
  input wire logic QRY_EMPTY_I,
  input wire logic QRY_INTERRUPT_I,
  input wire logic QRY_DEADLOCK_I,
  input wire logic DEV_ERR_I,
  input wire logic EXEC_ERR_I,
  input wire logic CMD_ERR_I,
  // Saved settings offered at power-up
  input wire logic NV_PSC_I,
  input wire logic [status_pkg::STD_W-1:0] NV_STD_MASK_I,
  input wire logic [status_pkg::STB_W-1:0] NV_SRE_I,
  // Bus-side poll and output control
  input wire logic SPOLL_I,
  input wire logic OUTPUT_ON_I,
  // Read-back values
  output logic [status_pkg::QUES_W-1:0] QUES_EVENT_O,
  output logic [status_pkg::STD_W-1:0] ESR_O,
  output logic [status_pkg::QUES_W-1:0] QUES_MASK_O,
  output logic [status_pkg::STD_W-1:0] STD_MASK_O,
  output logic [status_pkg::STB_W-1:0] SRE_O,
  output logic PSC_O,
  // Status byte and service request
  output logic [status_pkg::STB_W-1:0] STB_O,
  output logic [status_pkg::STB_W-1:0] SPOLL_BYTE_O,
  output logic SRQ_O,
  // Main output enable
  output logic OUTPUT_EN_O
);
  import status_pkg::*;

  // Group carriers
  evt_if #(.W(QUES_W)) ques_c ();
  evt_if #(.W(STD_W)) std_c ();

  // Questionable-data group
  event_group #(.W(QUES_W), .USED(QUES_USED)) u_ques (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .g(ques_c.grp)
  );

  // Standard-event group
  event_group #(.W(STD_W), .USED(STD_USED)) u_std (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .g(std_c.grp)
  );

  // Filtered pin levels: overload, unlock, external reference
  logic [2:0] pin_lvl;
  // Previous filtered levels for edge detection
  logic [2:0] pin_prev;

  pin_sync #(.W(3)) u_sync (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .d_i({EXTREF_PIN_I, UNLOCK_PIN_I, OVLD_PIN_I}),
    .q_o(pin_lvl)
  );

  // Calibration level history for edge detection
  logic cal_lost_prev;
  logic cal_unsec_prev;

  // Power-up sequencer state
  boot_t boot;
  boot_t next_boot;

  // Pending operation-complete request
  logic opc_armed;

  // Previous master summary for rise detection
  logic master_prev;

  // Request-service flag shown in the poll byte
  logic rqs;

  // Pin, loss and unsecure events latch on the condition turning on, not while it stays on
  wire logic ovld_rise = pin_lvl[0] & ~pin_prev[0];
  wire logic unlock_rise = pin_lvl[1] & ~pin_prev[1];
  wire logic extref_rise = pin_lvl[2] & ~pin_prev[2];
  wire logic lost_rise = CAL_LOST_I & ~cal_lost_prev;
  wire logic unsec_rise = CAL_UNSEC_I & ~cal_unsec_prev;

  // Any calibration cause feeds one bit
  wire logic cal_event = CAL_FAIL_I | lost_rise | unsec_rise; // [R9]

  // Operation complete needs the parser idle and no overlapped work left
  wire logic opc_done = opc_armed & CMD_IDLE_I & ~OVERLAP_BUSY_I; // [R4] [R14]

  // Any of the three query faults
  wire logic query_fault = QRY_EMPTY_I | QRY_INTERRUPT_I | QRY_DEADLOCK_I; // [R15]

  // Second running cycle marks power applied; the first loads saved settings
  wire logic boot_load = (boot == BOOT_LOAD);
  wire logic boot_mark = (boot == BOOT_MARK);

  // Questionable event strobes by bit position
  logic [QUES_W-1:0] ques_set;
  always_comb begin
    ques_set = '0;
    ques_set[QB_OVERLOAD] = ovld_rise; // [R7]
    ques_set[QB_UNLOCK] = unlock_rise; // [R8]
    ques_set[QB_CAL] = cal_event; // [R9]
    ques_set[QB_EXTREF] = extref_rise; // [R10]
  end

  // Standard event strobes by bit position
  logic [STD_W-1:0] std_set;
  always_comb begin
    std_set = '0;
    std_set[SB_OPC] = opc_done; // [R4]
    std_set[SB_QUERY] = query_fault; // [R15]
    std_set[SB_DEVICE] = DEV_ERR_I; // [R16]
    std_set[SB_EXEC] = EXEC_ERR_I; // [R17]
    std_set[SB_CMD] = CMD_ERR_I; // [R17]
    std_set[SB_PWR] = boot_mark; // [R18]
  end

  // Questionable group drive
  assign ques_c.set_ev = ques_set;
  assign ques_c.clear_ev = CLS_I | QUES_RD_I; // [R12]
  // Preset clears the mask through the same load path
  assign ques_c.mask_wr = QUES_MASK_WR_I | PRESET_I; // [R13]
  assign ques_c.mask_wdata = PRESET_I ? QUES_MASK_RST : WDATA_I; // [R13] [R6]

  // Standard group drive
  assign std_c.set_ev = std_set;
  assign std_c.clear_ev = CLS_I | ESR_RD_I; // [R19]
  // At power-up the saved mask survives only when clearing is off
  assign std_c.mask_wr = STD_MASK_WR_I | boot_load; // [R20]
  assign std_c.mask_wdata = boot_load ? (NV_PSC_I ? STD_MASK_RST : NV_STD_MASK_I)
                                      : WDATA_I[STD_W-1:0]; // [R20]

  // Status byte condition, master bit filled in below
  logic [STB_W-1:0] stb_cond;
  always_comb begin
    stb_cond = '0;
    stb_cond[YB_ERRQ] = ERRQ_NONEMPTY_I;
    stb_cond[YB_QUES] = ques_c.summary; // [R6]
    stb_cond[YB_MAV] = OUT_PENDING_I; // [R1]
    stb_cond[YB_STD] = std_c.summary; // [R5]
  end

  // Master summary over the enabled condition bits
  wire logic master = |(stb_cond & SRE_O & SRE_USED); // [R22]
  wire logic master_rise = master & ~master_prev;

  // Full status byte as software reads it
  logic [STB_W-1:0] stb_full;
  always_comb begin
    stb_full = stb_cond;
    stb_full[YB_RQS] = master;
  end

  // Request flag: a new rise beats a poll in the same cycle
  logic next_rqs;
  assign next_rqs = master_rise | (rqs & ~SPOLL_I); // [R22]

  // Poll response carries the request flag instead of the master bit
  logic [STB_W-1:0] next_poll;
  always_comb begin
    next_poll = stb_cond;
    next_poll[YB_RQS] = next_rqs;
  end

  // Power-up sequencer next state
  always_comb begin
    case (boot)
      BOOT_LOAD: next_boot = BOOT_MARK;
      BOOT_MARK: next_boot = BOOT_RUN;
      BOOT_RUN: next_boot = BOOT_RUN;
      default: next_boot = BOOT_LOAD;
    endcase
  end

  // Sequencer register
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      boot <= BOOT_LOAD;
    end else begin
      boot <= next_boot;
    end
  end

  // Edge history for conditions
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pin_prev <= '0;
      cal_lost_prev <= 1'b0;
      cal_unsec_prev <= 1'b0;
      master_prev <= 1'b0;
    end else begin
      pin_prev <= pin_lvl;
      cal_lost_prev <= CAL_LOST_I;
      cal_unsec_prev <= CAL_UNSEC_I;
      master_prev <= master;
    end
  end

  // Operation-complete request; clear-all cancels, a new request wins
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      opc_armed <= 1'b0;
    end else if (OPC_I) begin
      opc_armed <= 1'b1;
    end else if (CLS_I | opc_done) begin
      opc_armed <= 1'b0; // [R14]
    end
  end

  // Service-request flag and bus line
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rqs <= 1'b0;
      SRQ_O <= 1'b0;
    end else begin
      rqs <= next_rqs;
      SRQ_O <= next_rqs; // [R22]
    end
  end

  // Status byte enable; power-up value depends on the clear setting
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SRE_O <= SRE_RST;
    end else if (boot_load) begin
      SRE_O <= NV_PSC_I ? SRE_RST : (NV_SRE_I & SRE_USED);
    end else if (SRE_WR_I) begin
      SRE_O <= WDATA_I[STB_W-1:0] & SRE_USED; // [R5] [R11]
    end
  end

  // Power-on clear setting, taken from storage after release
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PSC_O <= PSC_RST;
    end else if (boot_load) begin
      PSC_O <= NV_PSC_I;
    end else if (PSC_WR_I) begin
      PSC_O <= WDATA_I[0];
    end
  end

  // Read data captured on the clearing read, so the reply holds the old bits
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      QUES_EVENT_O <= '0;
      ESR_O <= '0;
    end else begin
      if (QUES_RD_I) begin
        QUES_EVENT_O <= ques_c.event_q; // [R12]
      end
      if (ESR_RD_I) begin
        ESR_O <= std_c.event_q; // [R19]
      end
    end
  end

  // Mask mirrors; one cycle behind the group registers
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      QUES_MASK_O <= QUES_MASK_RST;
      STD_MASK_O <= STD_MASK_RST;
    end else begin
      QUES_MASK_O <= ques_c.mask_q;
      STD_MASK_O <= std_c.mask_q;
    end
  end

  // Status byte and poll byte, registered for clean outputs
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      STB_O <= '0;
      SPOLL_BYTE_O <= '0;
    end else begin
      STB_O <= stb_full; // [R1] [R5]
      SPOLL_BYTE_O <= next_poll;
    end
  end

  // Output enable; an overload always beats a turn-on request
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      OUTPUT_EN_O <= 1'b0;
    end else if (ovld_rise | pin_lvl[0]) begin
      OUTPUT_EN_O <= 1'b0; // [R7]
    end else if (OUTPUT_ON_I) begin
      OUTPUT_EN_O <= 1'b1;
    end
  end

  // Host side sequencing is relied on, not enforced here
  // Unmasking bit 0 before commands is the host's job
  // Arming order for service requests is the host's job
endmodule : status_event_reporting

// >>> status_event_reporting_chk.sv
// Port-level assertions for the status event reporting block
`timescale 1ns/1ps
module status_event_reporting_chk (
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RST_N_I,
  // Inputs that cause checked effects
  input wire logic OVLD_PIN_I,
  input wire logic OUT_PENDING_I,
  input wire logic PRESET_I,
  input wire logic QUES_MASK_WR_I,
  input wire logic STD_MASK_WR_I,
  input wire logic [status_pkg::QUES_W-1:0] WDATA_I,
  input wire logic SPOLL_I,
  // Outputs under watch
  input wire logic [status_pkg::QUES_W-1:0] QUES_EVENT_O,
  input wire logic [status_pkg::STD_W-1:0] ESR_O,
  input wire logic [status_pkg::QUES_W-1:0] QUES_MASK_O,
  input wire logic [status_pkg::STD_W-1:0] STD_MASK_O,
  input wire logic [status_pkg::STB_W-1:0] SRE_O,
  input wire logic [status_pkg::STB_W-1:0] STB_O,
  input wire logic [status_pkg::STB_W-1:0] SPOLL_BYTE_O,
  input wire logic SRQ_O,
  input wire logic OUTPUT_EN_O
);
  import status_pkg::*;
  // High from the second running cycle; boot-cycle standard-mask writes are lost
  logic up;
  // Boot marker
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      up <= 1'b0;
    end else begin
      up <= 1'b1;
    end
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  // Message-available tracks pending output one cycle late
  property p_mav;
    1'b1 |=> STB_O[YB_MAV] == $past(OUT_PENDING_I);
  endproperty
  a_mav: assert property (p_mav) else $error("mav bit wrong");
  // Unused positions never show a one
  property p_unused;
    STB_O[1:0] == 2'h0 && !STB_O[7] && (QUES_EVENT_O & ~QUES_USED) == 16'h0000
      && (QUES_MASK_O & ~QUES_USED) == 16'h0000 && (ESR_O & ~STD_USED) == 8'h00
      && (STD_MASK_O & ~STD_USED) == 8'h00 && (SRE_O & ~SRE_USED) == 8'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");
  // A cleared mask silences each summary
  property p_std_sum;
    (STD_MASK_O == 8'h00) [*2] |-> !STB_O[YB_STD];
  endproperty
  a_std_sum: assert property (p_std_sum) else $error("std summary unmasked");
  property p_ques_sum;
    (QUES_MASK_O == 16'h0000) [*2] |-> !STB_O[YB_QUES];
  endproperty
  a_ques_sum: assert property (p_ques_sum) else $error("ques summary unmasked");
  // Master rise raises the request line within two cycles
  property p_srq_rise;
    $rose(STB_O[YB_RQS]) |-> ##[0:2] SRQ_O;
  endproperty
  a_srq_rise: assert property (p_srq_rise) else $error("no service request");
  property p_srq_hold;
    SRQ_O && !SPOLL_I |=> SRQ_O;
  endproperty
  a_srq_hold: assert property (p_srq_hold) else $error("request dropped");
  // Poll with master steady high clears request and flag only
  property p_srq_clr;
    $past(STB_O[YB_RQS]) && SPOLL_I && STB_O[YB_RQS] ##1 STB_O[YB_RQS] |-> !SRQ_O && !SPOLL_BYTE_O[YB_RQS];
  endproperty
  a_srq_clr: assert property (p_srq_clr) else $error("poll did not clear");
  // Filter settles well inside eight cycles
  property p_ovld;
    OVLD_PIN_I [*8] |-> !OUTPUT_EN_O;
  endproperty
  a_ovld: assert property (p_ovld) else $error("output on in overload");
  property p_std_zero;
    up && STD_MASK_WR_I && WDATA_I[7:0] == 8'h00 |-> ##2 STD_MASK_O == 8'h00;
  endproperty
  a_std_zero: assert property (p_std_zero) else $error("std mask not cleared");
  property p_ques_zero;
    PRESET_I || QUES_MASK_WR_I && WDATA_I == 16'h0000 |-> ##2 QUES_MASK_O == 16'h0000;
  endproperty
  a_ques_zero: assert property (p_ques_zero) else $error("ques mask not cleared");
  // Main scenarios reached
  c_poll: cover property (SRQ_O && SPOLL_I);
  c_off: cover property ($fell(OUTPUT_EN_O));
  c_std: cover property ($rose(STB_O[YB_STD]));
endmodule : status_event_reporting_chk
bind status_event_reporting status_event_reporting_chk status_event_reporting_chk_i (
  .MCLK_I, .RST_N_I, .OVLD_PIN_I, .OUT_PENDING_I, .PRESET_I, .QUES_MASK_WR_I,
  .STD_MASK_WR_I, .WDATA_I, .SPOLL_I, .QUES_EVENT_O, .ESR_O, .QUES_MASK_O,
  .STD_MASK_O, .SRE_O, .STB_O, .SPOLL_BYTE_O, .SRQ_O, .OUTPUT_EN_O
);

// >>> host_model.sv
// Remote host model issuing status commands and serial polls
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic clk_i,
  // Command strobes, bit 9 is the serial poll
  output logic [9:0] cmd_o,
  // Write data
  output logic [15:0] wdata_o
);
  // Idle bus at time zero
  initial begin
    cmd_o = 10'h000;
    wdata_o = 16'h5a5a;
  end
  // One-cycle strobe; released data is inverted so it never looks valid
  task automatic cmd(input int k, input logic [15:0] d);
    @(posedge clk_i);
    cmd_o[k] <= 1'b1;
    wdata_o <= d;
    @(posedge clk_i);
    cmd_o[k] <= 1'b0;
    wdata_o <= ~d;
  endtask : cmd
  // Service request set-up in the fixed host order
  task automatic arm(input logic [7:0] ese, input logic [7:0] sre);
    cmd(0, 16'h0000);
    cmd(5, {8'h00, ese});
    cmd(6, {8'h00, sre});
  endtask : arm
endmodule : host_model

// >>> status_event_reporting_test.sv
// Self-checking bench for the status event reporting block
`timescale 1ns/1ps
module status_event_reporting_test;
  import status_pkg::*;
  // Expected result and which output holds it
  typedef struct {logic [3:0] sel; logic [15:0] val;} note_t;
  logic clk;
  logic rst_n;
  logic [16:0] x; // Condition lines and pulses
  logic nv_psc;
  logic [7:0] nv_std;
  logic [7:0] nv_sre;
  wire [9:0] h; // Host strobes
  wire [15:0] wd;
  logic [15:0] qev, qmask, m;
  logic [7:0] esr, smask, sre, stb, spb;
  logic psc, srq, oen, qrd_d, erd_d;
  note_t q[$];
  int n_fail = 0;
  int n_checks = 0;
  int seed, i;
  status_event_reporting status_event_reporting_i (
    .MCLK_I(clk), .RST_N_I(rst_n), .OVLD_PIN_I(x[0]), .UNLOCK_PIN_I(x[1]), .EXTREF_PIN_I(x[2]),
    .CAL_FAIL_I(x[3]), .CAL_LOST_I(x[4]), .CAL_UNSEC_I(x[5]), .CLS_I(h[0]), .PRESET_I(h[1]),
    .QUES_RD_I(h[2]), .ESR_RD_I(h[3]), .QUES_MASK_WR_I(h[4]), .STD_MASK_WR_I(h[5]), .SRE_WR_I(h[6]),
    .PSC_WR_I(h[7]), .OPC_I(h[8]), .WDATA_I(wd), .CMD_IDLE_I(x[6]), .OVERLAP_BUSY_I(x[7]),
    .OUT_PENDING_I(x[8]), .ERRQ_NONEMPTY_I(x[9]), .QRY_EMPTY_I(x[10]), .QRY_INTERRUPT_I(x[11]),
    .QRY_DEADLOCK_I(x[12]), .DEV_ERR_I(x[13]), .EXEC_ERR_I(x[14]), .CMD_ERR_I(x[15]),
    .NV_PSC_I(nv_psc), .NV_STD_MASK_I(nv_std), .NV_SRE_I(nv_sre), .SPOLL_I(h[9]), .OUTPUT_ON_I(x[16]),
    .QUES_EVENT_O(qev), .ESR_O(esr), .QUES_MASK_O(qmask), .STD_MASK_O(smask), .SRE_O(sre),
    .PSC_O(psc), .STB_O(stb), .SPOLL_BYTE_O(spb), .SRQ_O(srq), .OUTPUT_EN_O(oen)
  );
  host_model host_model_i (.clk_i(clk), .cmd_o(h), .wdata_o(wd));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Output picked by a note
  function automatic logic [15:0] probe(input logic [3:0] s);
    case (s)
      4'h0: probe = qev;
      4'h1: probe = {8'h00, esr};
      4'h2: probe = {8'h00, stb};
      4'h3: probe = qmask;
      4'h4: probe = {8'h00, smask};
      4'h5: probe = {8'h00, sre};
      4'h6: probe = {8'h00, spb};
      default: probe = {13'h0, srq, oen, psc};
    endcase
  endfunction : probe
  // Read strobes as the design took them
  always @(posedge clk) begin
    qrd_d <= h[2];
    erd_d <= h[3];
  end
  // Oldest note against settled outputs, mid-cycle
  always @(negedge clk) begin
    if (q.size() > 0 && (qrd_d || erd_d || q[0].sel > 4'h1)) begin
      n_checks++;
      if (probe(q[0].sel) !== q[0].val) begin
        n_fail++;
        $display("Error at %0t: got %h expected %h", $time, probe(q[0].sel), q[0].val);
      end
      void'(q.pop_front());
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Immediate check once effects have settled
  task automatic see(input logic [3:0] s, input logic [15:0] v);
    tick(6);
    q.push_back('{s, v});
  endtask : see
  // Event query: 2 is questionable, 3 is standard
  task automatic rd(input int k, input logic [15:0] v);
    host_model_i.cmd(k, 16'h0000);
    q.push_back('{(k == 2) ? 4'h0 : 4'h1, v});
  endtask : rd
  task automatic power(input logic p);
    nv_psc <= p;
    rst_n <= 1'b0;
    tick(8);
    rst_n <= 1'b1;
    tick(3);
  endtask : power
  task automatic final_report;
    // Let the last note be compared; one left over is a miss
    tick(2);
    if (q.size() > 0) begin
      n_fail++;
    end
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  // Bounded wait for the service request
  task automatic wait_srq;
    for (int j = 0; j < 20 && srq !== 1'b1; j++) @(negedge clk);
    if (srq !== 1'b1) begin
      n_fail++;
      final_report();
    end
  endtask : wait_srq
  // Main sequence
  initial begin
    seed = 34611;
    x = 17'h00040; // Command engine idle
    rst_n = 1'b0;
    nv_std = 8'hff;
    nv_sre = 8'hff;
    power(1'b0);
    see(4'h4, {8'h00, STD_USED});
    see(4'h5, {8'h00, SRE_USED});
    see(4'h3, 16'h0000);
    see(4'h2, 16'h0060);
    rd(3, 16'h0080);
    rd(3, 16'h0000);
    host_model_i.cmd(9, 16'h0000);
    see(4'h7, 16'h0000);
    host_model_i.arm(8'h01, 8'h20);
    x[7:6] <= 2'h2; // Overlapped work running, engine busy
    host_model_i.cmd(8, 16'h0000);
    see(4'h2, 16'h0000);
    x[6] <= 1'b1;
    see(4'h2, 16'h0000);
    x[7] <= 1'b0;
    wait_srq();
    see(4'h2, 16'h0060);
    see(4'h6, 16'h0060);
    host_model_i.cmd(9, 16'h0000);
    see(4'h6, 16'h0020);
    see(4'h2, 16'h0060);
    rd(3, 16'h0001);
    see(4'h2, 16'h0000);
    host_model_i.cmd(5, 16'h0000);
    see(4'h4, 16'h0000);
    // Each standard error source in turn
    for (i = 10; i < 16; i++) begin
      x[i] <= 1'b1;
      tick(1);
      x[i] <= 1'b0;
      rd(3, 16'h0001 << ((i < 13) ? 2 : i - 10));
    end
    // Random masks; unused bits must drop
    repeat (4) begin
      m = 16'($random(seed));
      host_model_i.cmd(4, m);
      see(4'h3, m & QUES_USED);
    end
    host_model_i.cmd(4, 16'h0020);
    x[16] <= 1'b1;
    tick(1);
    x[16] <= 1'b0;
    see(4'h7, 16'h0002);
    x[5:0] <= 6'h3f; // All questionable causes at once
    tick(1);
    x[3] <= 1'b0;
    see(4'h7, 16'h0000);
    see(4'h2, 16'h0008);
    host_model_i.cmd(1, 16'h0000);
    see(4'h2, 16'h0000);
    rd(2, 16'h0321);
    rd(2, 16'h0000);
    x[3] <= 1'b1;
    x[13] <= 1'b1;
    tick(1);
    x[3] <= 1'b0;
    x[13] <= 1'b0;
    host_model_i.cmd(0, 16'h0000);
    rd(2, 16'h0000);
    rd(3, 16'h0000);
    x[9:8] <= 2'h3;
    see(4'h2, 16'h0014);
    x[9:8] <= 2'h0;
    see(4'h2, 16'h0000);
    x[5:0] <= 6'h00;
    host_model_i.cmd(4, 16'h0001);
    power(1'b1);
    see(4'h3, 16'h0000);
    see(4'h4, 16'h0000);
    see(4'h5, 16'h0000);
    see(4'h7, 16'h0001);
    rd(3, 16'h0080);
    host_model_i.cmd(7, 16'h0000);
    see(4'h7, 16'h0000);
    final_report();
  end
endmodule : status_event_reporting_test
